// ==== pkg/wb_fmt_pkg.sv ====
package wb_fmt_pkg;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;

  // control register fields
  localparam int CTRL_DI_BIT = 0;
  localparam int CTRL_PARTIAL_BIT = 1;
  localparam int CTRL_DN_BIT = 2;
  localparam int CTRL_422_BIT = 3;
  localparam int CTRL_START_BIT = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FMT_LSB = 4;
  localparam int STAT_LEN_LSB = 8;

  // response lengths in registers
  localparam logic [3:0] LEN_DI_DN_422 = 4'hc;
  localparam logic [3:0] LEN_DI_DN = 4'hb;
  localparam logic [3:0] LEN_DI = 4'ha;
  localparam logic [3:0] LEN_DN_422 = 4'h9;
  localparam logic [3:0] LEN_DN = 4'h5;

  // slot positions inside a response
  localparam logic [3:0] DI_MOTION_SLOT = 4'h8;
  localparam logic [3:0] DI_NOISE_SLOT = 4'h9;
  localparam logic [3:0] DI_LUMA2_SLOT = 4'ha;
  localparam logic [3:0] DN_NOISE_SLOT = 4'h4;

  // register kinds carried by one response slot
  typedef enum logic [1:0] {
    KIND_LUMA = 2'h0,
    KIND_CHROMA = 2'h1,
    KIND_MOTION = 2'h2,
    KIND_NOISE = 2'h3
  } kind_e;

  // writeback format chosen at start
  typedef enum logic [1:0] {
    FMT_DI = 2'h0,
    FMT_DN_ONLY = 2'h1,
    FMT_PARTIAL = 2'h2
  } fmt_e;

  // per-block statistics delivered by the filter
  typedef struct packed {
    logic [15:0] y_pos;
    logic [15:0] x_pos;
    logic [15:0] tad_top;
    logic [15:0] hsum_top;
    logic [15:0] vsum_top;
    logic [15:0] tad_bot;
    logic [15:0] hsum_bot;
    logic [15:0] vsum_bot;
    logic [15:0] cur_top_prev_top_diff;
    logic [15:0] cur_bot_prev_bot_diff;
    logic [15:0] cur_top_cur_bot_diff;
    logic [15:0] cur_top_prev_bot_diff;
    logic [15:0] cur_bot_prev_top_diff;
    logic [7:0] tearing_count;
    logic [7:0] fitting_count;
    logic [7:0] motion_count;
    logic [7:0] noise_est;
    logic [7:0][7:0] history;
  } stats_s;

  // one outgoing 256-bit response register
  typedef struct packed {
    logic [255:0] data;
    logic [3:0] slot;
    logic last;
  } wb_word_s;

endpackage

// ==== rtl/block_packer.sv ====
`timescale 1ns/10ps
// lays 32 source bytes out as one 8-dword response register
module block_packer (
  // element bytes, element i at bits 8i+7:8i
  input wire logic [255:0] src_bytes,
  input wire wb_fmt_pkg::kind_e kind,
  // packed register
  output logic [255:0] packed_reg
);

  // one dword per loop pass
  genvar d;
  generate
    for (d = 0; d < 8; d++)
    begin : g_dword
      wire [31:0] src_dw = src_bytes[32*d +: 32];
      // chroma: cb of each pair to the upper byte of its half
      wire [31:0] chroma_dw = {src_dw[23:16], src_dw[31:24],
                               src_dw[7:0], src_dw[15:8]}; // R4
      // luma and motion keep lowest x in the low byte
      assign packed_reg[32*d +: 32] =
        (kind == wb_fmt_pkg::KIND_CHROMA) ? chroma_dw : src_dw; // R3 R5
    end
  endgenerate

endmodule // block_packer

// ==== rtl/deinterlace_writeback_formatter.sv ====
`timescale 1ns/10ps
// Functional notes
// [R1] three writeback formats, chosen by deinterlace and partial settings
// [R2] every block fills one whole 8-dword register
// [R3] luma: 16 bytes per row, row 0 low dwords, lowest x low byte
// [R4] chroma: cb/cr pairs for even x, cb in upper byte of each half
// [R5] motion: even x 0..14, rows 0..3, two dwords per row
// [R6] noise dword 7: vertical position high, horizontal position low
// [R7] deinterlaced temporal/horizontal/vertical sums, zero when denoise off
// [R8] five field-difference sums in dwords 5 low down to 3 low
// [R9] tearing and fitting counts in dword 1 high; dword 2 reserved
// [R10] motion count in dword 1 bits 15:8, noise estimate bits 7:0
// [R11] four history bytes in dword 0, highest column group on top
// [R12] no deinterlace: top half sums in dwords 6 and 5 high
// [R13] no deinterlace: bottom half sums in dword 5 low and dword 4
// [R14] no deinterlace: dword 3 reserved, noise estimate in dword 2 low
// [R15] no deinterlace: eight history bytes, rows 7..4 in dword 1
// [R16] deinterlace enable always selects the deinterlace format
// [R17] deinterlace lengths 12, 11 or 10 by denoise and 4:2:2 input
// [R18] deinterlace order: prev luma, chroma, cur luma, chroma, motion, noise
// [R19] second-field luma, and chroma for 4:2:2, only with denoise
// [R20] no deinterlace: 16x8 block, length 9 for 4:2:2, else 5
// [R21] reserved ranges in returned registers are zero
module deinterlace_writeback_formatter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // statistics, sampled when a response starts
  input wire wb_fmt_pkg::stats_s stats,
  // pixel source, one 32-byte block per handshake
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [255:0] src_bytes,
  output wb_fmt_pkg::kind_e src_kind,
  // response registers toward the thread
  output logic wb_valid,
  input wire logic wb_ready,
  output wb_fmt_pkg::wb_word_s wb_word
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DRAIN = 3'b100
  } state_e;

  state_e state_q, state_d;
  logic [3:0] ctrl_q, ctrl_d;
  wb_fmt_pkg::fmt_e fmt_q, fmt_d;
  logic dn_q, dn_d;
  logic fmt422_q, fmt422_d;
  logic [3:0] len_q, len_d;
  logic [3:0] slot_q, slot_d;
  wb_fmt_pkg::stats_s stats_q, stats_d;
  logic [15:0] count_q, count_d;
  logic [31:0] prdata_q, prdata_d;
  logic wb_valid_q, wb_valid_d;
  wb_fmt_pkg::wb_word_s word_q, word_d;

  // apb decode
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_ctrl = (paddr == wb_fmt_pkg::CTRL_OFS);
  wire hit_status = (paddr == wb_fmt_pkg::STATUS_OFS);
  wire hit_count = (paddr == wb_fmt_pkg::COUNT_OFS);
  wire mapped = hit_ctrl | hit_status | hit_count;
  wire ctrl_wr = access_phase & pwrite & hit_ctrl;
  wire busy = (state_q != ST_IDLE);
  // a start while busy is dropped so the running response stays whole
  wire start = ctrl_wr & pwdata[wb_fmt_pkg::CTRL_START_BIT] & ~busy;

  // settings as written, start bit not stored
  wire [3:0] ctrl_wdata = pwdata[3:0];
  wire set_di = ctrl_wdata[wb_fmt_pkg::CTRL_DI_BIT];
  wire set_partial = ctrl_wdata[wb_fmt_pkg::CTRL_PARTIAL_BIT];
  wire set_dn = ctrl_wdata[wb_fmt_pkg::CTRL_DN_BIT];
  wire set_422 = ctrl_wdata[wb_fmt_pkg::CTRL_422_BIT];

  // format pick; enable wins over partial
  wire wb_fmt_pkg::fmt_e fmt_pick =
    set_di ? wb_fmt_pkg::FMT_DI : // R16 R1
    set_partial ? wb_fmt_pkg::FMT_PARTIAL : wb_fmt_pkg::FMT_DN_ONLY; // R1
  wire di_pick = (fmt_pick == wb_fmt_pkg::FMT_DI);

  // response length for the format about to start
  wire [3:0] len_di = ~set_dn ? wb_fmt_pkg::LEN_DI :
                      set_422 ? wb_fmt_pkg::LEN_DI_DN_422 :
                      wb_fmt_pkg::LEN_DI_DN; // R17 R19
  wire [3:0] len_dn = set_422 ? wb_fmt_pkg::LEN_DN_422 :
                      wb_fmt_pkg::LEN_DN; // R20
  wire [3:0] len_pick = di_pick ? len_di : len_dn;

  // read mux, bits above each field read as zero
  wire [31:0] status_word =
    {20'h0_0000, len_q, 2'b00, fmt_q, 3'b000, busy};
  wire [31:0] rd_mux =
    hit_ctrl ? {28'h000_0000, ctrl_q} :
    hit_status ? status_word :
    hit_count ? {16'h0000, count_q} : 32'h0000_0000;

  // bus answers at once; unmapped addresses give an error
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;
  assign prdata = prdata_q;

  // kind of register carried by a slot
  function automatic wb_fmt_pkg::kind_e slot_kind(
    input wb_fmt_pkg::fmt_e fmt,
    input logic [3:0] slot
  );
    wb_fmt_pkg::kind_e k;
    k = wb_fmt_pkg::KIND_LUMA;
    if (fmt == wb_fmt_pkg::FMT_DI)
    begin
      // prev luma, prev chroma, cur luma, cur chroma in pairs
      if (slot < wb_fmt_pkg::DI_MOTION_SLOT)
        k = slot[1] ? wb_fmt_pkg::KIND_CHROMA
                    : wb_fmt_pkg::KIND_LUMA; // R18
      else if (slot == wb_fmt_pkg::DI_MOTION_SLOT)
        k = wb_fmt_pkg::KIND_MOTION; // R18
      else if (slot == wb_fmt_pkg::DI_NOISE_SLOT)
        k = wb_fmt_pkg::KIND_NOISE; // R18
      else if (slot == wb_fmt_pkg::DI_LUMA2_SLOT)
        k = wb_fmt_pkg::KIND_LUMA; // R19
      else
        k = wb_fmt_pkg::KIND_CHROMA; // R19
    end
    else
    begin
      // four luma registers, statistics, then chroma when 4:2:2
      if (slot < wb_fmt_pkg::DN_NOISE_SLOT)
        k = wb_fmt_pkg::KIND_LUMA; // R20
      else if (slot == wb_fmt_pkg::DN_NOISE_SLOT)
        k = wb_fmt_pkg::KIND_NOISE; // R20
      else
        k = wb_fmt_pkg::KIND_CHROMA; // R20
    end
    return k;
  endfunction

  // statistics register with deinterlacing
  function automatic logic [255:0] noise_di(
    input wb_fmt_pkg::stats_s s,
    input logic dn
  );
    logic [15:0] tad;
    logic [15:0] hs;
    logic [15:0] vs;
    logic [31:0] dw [8];
    // sums are forced to zero without denoise
    tad = dn ? s.tad_top : 16'h0000; // R7
    hs = dn ? s.hsum_top : 16'h0000; // R7
    vs = dn ? s.vsum_top : 16'h0000; // R7
    dw[7] = {s.y_pos, s.x_pos}; // R6
    dw[6] = {tad, hs}; // R7
    dw[5] = {vs, s.cur_top_prev_top_diff}; // R7 R8
    dw[4] = {s.cur_bot_prev_bot_diff, s.cur_top_cur_bot_diff}; // R8
    dw[3] = {s.cur_top_prev_bot_diff, s.cur_bot_prev_top_diff}; // R8
    dw[2] = 32'h0000_0000; // R9 R21
    dw[1] = {s.tearing_count, s.fitting_count,
             s.motion_count, s.noise_est}; // R9 R10
    dw[0] = {s.history[3], s.history[2],
             s.history[1], s.history[0]}; // R11
    return {dw[7], dw[6], dw[5], dw[4], dw[3], dw[2], dw[1], dw[0]}; // R2
  endfunction

  // statistics register for the 16x8 block without deinterlacing
  function automatic logic [255:0] noise_dn(
    input wb_fmt_pkg::stats_s s
  );
    logic [31:0] dw [8];
    dw[7] = {s.y_pos, s.x_pos}; // R6
    dw[6] = {s.tad_top, s.hsum_top}; // R12
    dw[5] = {s.vsum_top, s.tad_bot}; // R12 R13
    dw[4] = {s.hsum_bot, s.vsum_bot}; // R13
    dw[3] = 32'h0000_0000; // R14 R21
    dw[2] = {24'h00_0000, s.noise_est}; // R14 R21
    dw[1] = {s.history[7], s.history[6],
             s.history[5], s.history[4]}; // R15
    dw[0] = {s.history[3], s.history[2],
             s.history[1], s.history[0]}; // R15
    return {dw[7], dw[6], dw[5], dw[4], dw[3], dw[2], dw[1], dw[0]}; // R2
  endfunction

  // current slot and what it needs
  wire wb_fmt_pkg::kind_e cur_kind = slot_kind(fmt_q, slot_q);
  wire needs_src = (cur_kind != wb_fmt_pkg::KIND_NOISE);
  wire out_free = ~wb_valid_q | wb_ready;
  wire running = (state_q == ST_RUN);
  wire last_slot = (slot_q == len_q - 4'h1);
  assign src_kind = cur_kind;
  assign src_ready = running & needs_src & out_free;
  wire load = running & out_free & (~needs_src | src_valid);

  // pixel blocks packed by the helper
  logic [255:0] pix_reg;
  block_packer u_packer (
    .src_bytes(src_bytes),
    .kind(cur_kind),
    .packed_reg(pix_reg)
  );

  // statistics layout follows the format, partial shares the 16x8 one
  wire [255:0] stat_reg = (fmt_q == wb_fmt_pkg::FMT_DI) ?
    noise_di(stats_q, dn_q) : noise_dn(stats_q); // R1
  wire [255:0] slot_data = needs_src ? pix_reg : stat_reg;

  // sequencer
  always_comb
  begin
    state_d = state_q;
    slot_d = slot_q;
    count_d = count_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          state_d = ST_RUN;
          slot_d = 4'h0;
        end
      end
      ST_RUN:
      begin
        if (load)
        begin
          slot_d = slot_q + 4'h1;
          if (last_slot)
            state_d = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        // done once the last register is taken
        if (wb_ready)
        begin
          state_d = ST_IDLE;
          count_d = count_q + 16'h0001;
        end
      end
    endcase
  end

  // settings latch at start, held for the whole response; ctrl_q follows every control write
  always_comb
  begin
    ctrl_d = ctrl_wr ? ctrl_wdata : ctrl_q;
    fmt_d = start ? fmt_pick : fmt_q;
    dn_d = start ? set_dn : dn_q;
    fmt422_d = start ? set_422 : fmt422_q;
    len_d = start ? len_pick : len_q;
    stats_d = start ? stats : stats_q;
    prdata_d = setup_phase ? rd_mux : prdata_q;
  end

  // output register; holds until the thread takes it
  always_comb
  begin
    wb_valid_d = wb_valid_q;
    word_d = word_q;
    if (load)
    begin
      wb_valid_d = 1'b1;
      word_d.data = slot_data; // R2
      word_d.slot = slot_q;
      word_d.last = last_slot;
    end
    else if (wb_ready)
      wb_valid_d = 1'b0;
  end

  assign wb_valid = wb_valid_q;
  assign wb_word = word_q;

  // control state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      slot_q <= 4'h0;
      count_q <= 16'h0000;
      ctrl_q <= wb_fmt_pkg::CTRL_RESET;
      fmt_q <= wb_fmt_pkg::FMT_DN_ONLY;
      dn_q <= 1'b0;
      fmt422_q <= 1'b0;
      len_q <= wb_fmt_pkg::LEN_DN;
    end
    else
    begin
      state_q <= state_d;
      slot_q <= slot_d;
      count_q <= count_d;
      ctrl_q <= ctrl_d;
      fmt_q <= fmt_d;
      dn_q <= dn_d;
      fmt422_q <= fmt422_d;
      len_q <= len_d;
    end
  end

  // datapath registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stats_q <= '0;
      prdata_q <= 32'h0000_0000;
      wb_valid_q <= 1'b0;
      word_q <= '0;
    end
    else
    begin
      stats_q <= stats_d;
      prdata_q <= prdata_d;
      wb_valid_q <= wb_valid_d;
      word_q <= word_d;
    end
  end

endmodule // deinterlace_writeback_formatter

// ==== verif/deinterlace_writeback_formatter_checker.sv ====
`timescale 1ns/10ps
// watches the response stream against settings latched at start
module deinterlace_writeback_formatter_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb and source side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire wb_fmt_pkg::stats_s stats,
  input wire logic src_valid,
  input wire logic src_ready,
  // response stream
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire wb_fmt_pkg::wb_word_s wb_word
);
  logic run_q, di_q, dn_q, f_q;
  logic [3:0] nxt_q;
  wb_fmt_pkg::stats_s st_q;
  // decode of start, length and the statistics slot
  wire logic hs = wb_valid & wb_ready;
  wire logic go = psel & penable & pwrite & pwdata[4] & !run_q &
    (paddr == wb_fmt_pkg::CTRL_OFS);
  wire logic [3:0] len = di_q ? (dn_q ? (f_q ? 4'hc : 4'hb) : 4'ha) :
    (f_q ? 4'h9 : 4'h5);
  wire logic nz = wb_valid & (wb_word.slot == (di_q ? 4'h9 : 4'h4));
  wire logic [255:0] d = wb_word.data;
  // shadow run state; a start while busy is dropped as in the block
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {run_q, di_q, dn_q, f_q, nxt_q} <= 8'h0;
      st_q <= '0;
    end
    else if (go)
    begin
      {run_q, di_q, dn_q, f_q} <= {1'b1, pwdata[0], pwdata[2], pwdata[3]};
      st_q <= stats;
    end
    else if (hs)
    begin
      run_q <= run_q & !wb_word.last;
      nxt_q <= wb_word.last ? 4'h0 : wb_word.slot + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; src_valid && src_ready; endsequence
  sequence s_dn_noise; nz && !di_q; endsequence
  chk_take_word: assert property (s_take |=> wb_valid)
    else $error("no register after source block");
  chk_word_hold: assert property (wb_valid && !wb_ready |=>
    wb_valid && $stable(wb_word)) else $error("register not held");
  chk_slot_order: assert property (wb_valid |-> wb_word.slot == nxt_q)
    else $error("slot out of order");
  chk_last_len: assert property (wb_valid |->
    wb_word.last == (wb_word.slot == len - 4'h1)) else $error("bad length");
  chk_noise_pos: assert property (nz |->
    d[255:224] == {st_q.y_pos, st_q.x_pos}) else $error("bad position");
  chk_sum_zero: assert property (nz && di_q && !dn_q |->
    d[223:176] == 48'h0) else $error("sums not zero");
  chk_di_rsvd: assert property (nz && di_q |-> d[95:64] == 32'h0)
    else $error("reserved dword not zero");
  chk_dn_bottom: assert property (s_dn_noise |-> d[175:128] ==
    {st_q.tad_bot, st_q.hsum_bot, st_q.vsum_bot}) else $error("bad sums");
  chk_dn_rsvd: assert property (s_dn_noise |-> d[127:72] == 56'h0)
    else $error("reserved bits not zero");
endmodule // deinterlace_writeback_formatter_checker

bind deinterlace_writeback_formatter deinterlace_writeback_formatter_checker
  u_chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .stats,
  .src_valid, .src_ready, .wb_valid, .wb_ready, .wb_word);

// ==== verif/deinterlace_writeback_formatter_tb_top.sv ====
`timescale 1ns/10ps
// drives settings, blocks and stats; a monitor checks each register
module deinterlace_writeback_formatter_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, err, src_ready, wb_valid, wb_ready;
  wb_fmt_pkg::stats_s stats = '0;
  logic src_valid = 1'b0;
  logic [255:0] src_bytes = 256'h0;
  wb_fmt_pkg::kind_e src_kind;
  wb_fmt_pkg::wb_word_s wb_word;
  logic [3:0] resp_len;
  logic [260:0] exp_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 2787;
  int cyc = 0;
  int n_done = 0;
  deinterlace_writeback_formatter u_deinterlace_writeback_formatter (.clk,
    .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .stats, .src_valid, .src_ready, .src_bytes, .src_kind,
    .wb_valid, .wb_ready, .wb_word);
  thread_model u_thread_model (.clk, .rst_n, .wb_valid, .wb_ready,
    .wb_word, .resp_len);
  // clock
  initial forever #5 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [260:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // kind code of slot i: 0 luma, 1 chroma, 2 motion, 3 statistics
  function automatic logic [1:0] kd(logic [3:0] c, int i);
    if (c[0]) return i < 8 ? {1'b0, i[1]} : i == 8 ? 2'h2 :
      i == 9 ? 2'h3 : {1'b0, i[0]};
    return i < 4 ? 2'h0 : i == 4 ? 2'h3 : 2'h1;
  endfunction
  function automatic logic [3:0] ln(logic [3:0] c);
    return c[0] ? (c[2] ? (c[3] ? 4'hc : 4'hb) : 4'ha) :
      (c[3] ? 4'h9 : 4'h5);
  endfunction
  // statistics register, kept apart from the pixel path
  function automatic logic [255:0] nz(logic [3:0] c, wb_fmt_pkg::stats_s s);
    if (c[0]) return {s.y_pos, s.x_pos, c[2] ? {s.tad_top, s.hsum_top,
      s.vsum_top} : 48'h0, s.cur_top_prev_top_diff,
      s.cur_bot_prev_bot_diff, s.cur_top_cur_bot_diff, s.cur_top_prev_bot_diff,
      s.cur_bot_prev_top_diff, 32'h0, s.tearing_count, s.fitting_count,
      s.motion_count, s.noise_est, s.history[3:0]};
    return {s.y_pos, s.x_pos, s.tad_top, s.hsum_top, s.vsum_top,
      s.tad_bot, s.hsum_bot, s.vsum_bot, 56'h0, s.noise_est,
      s.history};
  endfunction
  // one whole response for settings c, with fresh stats
  task automatic run_one(input logic [3:0] c);
    logic [255:0] b;
    logic [319:0] r;
    logic [31:0] rd;
    logic [1:0] k;
    int n;
    for (int j = 0; j < 10; j++) r[32*j+:32] = $random(seed);
    stats <= r[303:0];
    n = ln(c);
    apb(1'b1, wb_fmt_pkg::CTRL_OFS, {27'h0, 1'b1, c}, rd);
    for (int i = 0; i < n; i++)
    begin
      k = kd(c, i);
      b = nz(c, stats);
      if (k != 2'h3)
      begin
        for (int j = 0; j < 8; j++) b[32*j+:32] = $random(seed);
        @(posedge clk);
        {src_valid, src_bytes} <= {1'b1, b};
        do @(posedge clk); while (src_ready !== 1'b1);
        check("src_kind", 261'(src_kind), 261'(k));
        {src_valid, src_bytes} <= {1'b0, ~b};
        for (int e = 0; e < 16 && k == 2'h1; e++)
          b[16*e+:16] = {b[16*e+:8], b[16*e+8+:8]};
      end
      exp_q.push_back({b, 4'(i), i == n - 1});
    end
    do apb(1'b0, wb_fmt_pkg::STATUS_OFS, 32'h0, rd); while (rd[0] !== 1'b0);
    check("status", 261'(rd), 261'({20'h0, n[3:0], 2'h0,
      c[0] ? 2'h0 : c[1] ? 2'h2 : 2'h1, 4'h0}));
    check("pending", 261'(exp_q.size()), 261'(0));
    check("length", 261'(resp_len), 261'(n));
    apb(1'b0, wb_fmt_pkg::CTRL_OFS, 32'h0, rd);
    check("ctrl", 261'({err, rd}), 261'({1'b0, 28'h0, c}));
    // finished responses are counted once the last register is taken
    n_done++;
    apb(1'b0, wb_fmt_pkg::COUNT_OFS, 32'h0, rd);
    check("count", 261'(rd), 261'(n_done));
  endtask
  // main sequence: reset, unmapped read, every setting twice
  initial
  begin
    logic [31:0] rd;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0, rd);
    check("unmapped", 261'({err, rd}), 261'({1'b1, 32'h0}));
    for (int i = 0; i < 32; i++) run_one(i[3:0]);
    complete_run;
  end
  // monitor: oldest expected register against each one taken
  always @(posedge clk)
    if (rst_n && wb_valid === 1'b1 && wb_ready === 1'b1)
      check("wb_word", wb_word, exp_q.size() != 0 ?
        exp_q.pop_front() : 'x);
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run;
    end
  end
endmodule // deinterlace_writeback_formatter_tb_top

// ==== verif/thread_model.sv ====
`timescale 1ns/10ps
// thread side: takes response registers, stalling at random
module thread_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // response registers
  input wire logic wb_valid,
  output logic wb_ready,
  input wire wb_fmt_pkg::wb_word_s wb_word,
  // register count of the last whole response
  output logic [3:0] resp_len
);
  int seed = 2787;
  logic [3:0] cnt_q;
  // stalls a quarter of the cycles so held registers get exercised
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {wb_ready, cnt_q, resp_len} <= 9'h0;
    end
    else
    begin
      wb_ready <= ($random(seed) & 3) != 0;
      if (wb_valid && wb_ready)
      begin
        cnt_q <= wb_word.last ? 4'h0 : cnt_q + 4'h1;
        resp_len <= wb_word.last ? cnt_q + 4'h1 : resp_len;
      end
    end
  end
endmodule // thread_model
